// [hw/ride_through_pkg.sv]
// What this block does
// - Flag reference loss on fast analog drop.
// - Loss response zero stops the drive.
// - Loss response one runs at post-loss reference.
// - Defaults: 80 percent, 10 percent, stop.
// - Output function C shows reference loss.
// - Eligible fault: self-check, then auto restart.
// - Attempt count setting limits restarts; default none.
// - Listed faults restart; others trip.
// - Undervoltage restarts only with ride-through one or two.
// - Output function 1E shows restart status.
// - Ten minutes clean running clears counter.
// - Fault reset after trip clears counter.
// - Power-up clears the restart counter.
// - Fan response zero: fan alarm only, continue.
// - Fan response one: fan fault coasts to stop.
// - Fan-fault running limits current to 80 percent.
// - Constant torque: 100%/3 min, 150%/15 s.
// - Variable torque: 100%/30 s, 120%/10 s.
// - Faulty fan rests 3 seconds each minute.
package ride_through_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ = 250000000;
  localparam longint LOSS_WINDOW_MS = 400;
  localparam longint LOSS_WINDOW_CYC = LOSS_WINDOW_MS * CLK_HZ / 1000;
  localparam longint CLEAN_RUN_MIN = 10;
  localparam longint CLEAN_RUN_CYC = CLEAN_RUN_MIN * 60 * CLK_HZ;
  localparam longint FAN_PERIOD_S = 60;
  localparam longint FAN_OFF_S = 3;
  localparam longint TICK_MS_CYC = CLK_HZ / 1000;
  localparam int DIAG_CYC = 16;

  // ---------------------------------------------------------------
  // Settings values and defaults
  // ---------------------------------------------------------------
  localparam logic [6:0] POST_LOSS_PCT_DEF = 7'h50;
  localparam logic [6:0] DETECT_WIDTH_DEF = 7'h0a;
  localparam logic LOSS_STOP = 1'b0;
  localparam logic LOSS_CONTINUE = 1'b1;
  localparam logic FAN_RESP_DEF = 1'b1;
  localparam logic [3:0] ATTEMPT_DEF = 4'h0;
  localparam logic [6:0] FAN_CURRENT_PCT = 7'h50;
  localparam logic [6:0] FULL_CURRENT_PCT = 7'h64;
  localparam logic [5:0] DOUT_REF_LOSS = 6'h0c;
  localparam logic [5:0] DOUT_ALARM = 6'h10;
  localparam logic [5:0] DOUT_RESTART = 6'h1e;
  localparam logic [5:0] DOUT_FAN = 6'h3d;
  localparam logic [5:0] DOUT_FAULT = 6'h0e;

  // Overload capacity figures: percent and seconds.
  localparam logic [7:0] CT_OL1_PCT = 8'h64;
  localparam logic [9:0] CT_OL1_S = 10'h0b4;
  localparam logic [7:0] CT_OL2_PCT = 8'h96;
  localparam logic [9:0] CT_OL2_S = 10'h00f;
  localparam logic [7:0] VT_OL1_PCT = 8'h64;
  localparam logic [9:0] VT_OL1_S = 10'h01e;
  localparam logic [7:0] VT_OL2_PCT = 8'h78;
  localparam logic [9:0] VT_OL2_S = 10'h00a;

  // Fault vector bit positions.
  localparam int F_OVERCURRENT = 0;
  localparam int F_GROUND = 1;
  localparam int F_BUS_FUSE = 2;
  localparam int F_OVERVOLTAGE = 3;
  localparam int F_UNDERVOLTAGE = 4;
  localparam int F_MOTOR_HEAT = 5;
  localparam int F_OVERTORQUE = 6;
  localparam int F_OUT_PHASE = 7;
  localparam int F_OTHER = 8;
  localparam int FAULT_W = 9;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RUN = 3'b001,
    ST_DIAG = 3'b011,
    ST_TRIP = 3'b010
  } drive_state_e;

  typedef struct packed {
    logic [7:0] pct1;
    logic [9:0] sec1;
    logic [7:0] pct2;
    logic [9:0] sec2;
  } overload_s;

  typedef struct packed {
    logic loss_response_sel;
    logic [6:0] post_loss_freq_pct;
    logic [6:0] ref_detect_width_pct;
    logic [3:0] restart_attempt_count;
    logic [1:0] power_loss_ride_sel;
    logic fan_fault_response_sel;
    logic [1:0] duty_rating_sel;
  } settings_s;

endpackage : ride_through_pkg

// [hw/drive_fault_ride_through.sv]
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/100ps
module drive_fault_ride_through
  import ride_through_pkg::*;
#(
  parameter int REF_W = 12,
  parameter int DOUT_N = 3,
  parameter longint LOSS_WINDOW_CYCLES = LOSS_WINDOW_CYC,
  parameter longint CLEAN_RUN_CYCLES = CLEAN_RUN_CYC,
  parameter longint TICK_CYCLES = TICK_MS_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave.
  input wire logic [3:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // Drive side.
  input wire logic run_cmd_i,
  input wire logic analog_ref_sel_i,
  input wire logic [REF_W-1:0] ref_value_i,
  input wire logic [FAULT_W-1:0] fault_i,
  input wire logic fin_overheat_fault_i,
  input wire logic fan_fault_i,
  input wire logic diag_ok_i,
  input wire logic fault_reset_i,
  output logic run_enable_o,
  output logic coast_stop_o,
  output logic [REF_W-1:0] freq_ref_o,
  output logic [6:0] current_limit_pct_o,
  output overload_s overload_o,
  output logic fan_on_o,
  output logic fan_indication_o,
  output logic [DOUT_N-1:0] dout_o
);

  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  if (REF_W < 8 || DOUT_N < 1 || LOSS_WINDOW_CYCLES < 1 || CLEAN_RUN_CYCLES < 1
      || TICK_CYCLES < 1) begin : g_bad_param
    $error("drive_fault_ride_through: parameter out of range");
  end

  localparam logic [31:0] A_SETTINGS = 32'h0;
  localparam logic [31:0] A_DOUT_SEL = 32'h1;
  localparam logic [31:0] A_STATUS = 32'h2;

  // Register storage.
  settings_s cfg;
  logic [DOUT_N-1:0][5:0] dout_sel;
  drive_state_e state;
  drive_state_e next_state;
  logic ref_lost;
  logic [3:0] restart_cnt;
  logic restarting;
  logic clean_seen;
  logic [REF_W-1:0] ref_base;
  logic [31:0] loss_cnt;
  logic [39:0] clean_cnt;
  logic [31:0] tick_cnt;
  logic [15:0] sec_ms;
  logic [5:0] sec_in_min;
  logic accepted;
  logic [DIAG_CYC-1:0] diag_sr;

  function automatic logic dout_match(input logic [5:0] sel, input logic [5:0] code);
    dout_match = (sel == code);
  endfunction : dout_match

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  // Each access is answered one cycle after it is presented.
  wire bus_req = read_i | write_i;
  wire bus_hit = bus_req & ~accepted;
  assign waitrequest_o = bus_req & ~accepted;
  wire wr_set = write_i & accepted & (32'(address_i) == A_SETTINGS);
  wire wr_dout = write_i & accepted & (32'(address_i) == A_DOUT_SEL);
  wire [31:0] status_word = {21'h0, restarting, ref_lost, state, restart_cnt};
  wire [31:0] dout_word = 32'(dout_sel);
  // Settings word keeps a spare bit at position 2 between fan response and duty.
  wire [31:0] set_word = {7'h0, cfg[23:2], 1'b0, cfg[1:0]};
  wire [31:0] rd_mux = (32'(address_i) == A_SETTINGS) ? set_word :
                       (32'(address_i) == A_DOUT_SEL) ? dout_word :
                       (32'(address_i) == A_STATUS) ? status_word : 32'h0;

  // Accept toggles the answer cycle.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      accepted <= 1'b0;
      readdata_o <= 32'h0;
    end else begin
      accepted <= bus_hit;
      if (bus_hit) begin
        readdata_o <= rd_mux;
      end
    end
  end

  // Settings registers with documented defaults.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg <= '{LOSS_STOP, POST_LOSS_PCT_DEF, DETECT_WIDTH_DEF, ATTEMPT_DEF,
               2'h0, FAN_RESP_DEF, 2'h0};
      dout_sel <= '0;
    end else begin
      if (wr_set) begin
        cfg <= {writedata_i[24:3], writedata_i[1:0]};
      end
      if (wr_dout) begin
        dout_sel <= writedata_i[6*DOUT_N-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Reference loss detection
  // ---------------------------------------------------------------
  // The base value refreshes every window while no loss is flagged; a drop below width percent of it flags loss.
  wire [REF_W+6:0] now_x100 = (REF_W+7)'(ref_value_i) * (REF_W+7)'(100);
  wire [REF_W+6:0] base_x_w = (REF_W+7)'(ref_base) * (REF_W+7)'(cfg.ref_detect_width_pct);
  wire loss_hit = analog_ref_sel_i & (now_x100 < base_x_w) & (ref_base != '0);
  wire window_end = (loss_cnt >= 32'(LOSS_WINDOW_CYCLES - 1));

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_base <= '0;
      loss_cnt <= 32'h0;
      ref_lost <= 1'b0;
    end else begin
      loss_cnt <= window_end ? 32'h0 : loss_cnt + 32'h1;
      if (window_end && !ref_lost) begin
        ref_base <= ref_value_i;
      end
      if (loss_hit) begin
        ref_lost <= 1'b1;
      end else if (!analog_ref_sel_i || fault_reset_i) begin
        ref_lost <= 1'b0;
      end
    end
  end

  // Post-loss reference is a percentage of the held base value.
  wire [REF_W+6:0] post_prod = (REF_W+7)'(ref_base) * (REF_W+7)'(cfg.post_loss_freq_pct);
  wire [REF_W-1:0] post_ref = REF_W'(post_prod / (REF_W+7)'(100));
  wire loss_stop = ref_lost & (cfg.loss_response_sel == LOSS_STOP);

  // ---------------------------------------------------------------
  // Fault classification and restart sequencing
  // ---------------------------------------------------------------
  wire uv_ok = (cfg.power_loss_ride_sel == 2'h1) || (cfg.power_loss_ride_sel == 2'h2);
  wire [FAULT_W-1:0] elig_mask = {1'b0, 3'h7, uv_ok, 4'hf};
  wire fan_trip = fan_fault_i & cfg.fan_fault_response_sel;
  wire any_elig = |(fault_i & elig_mask);
  wire any_hard = (|(fault_i & ~elig_mask)) | fin_overheat_fault_i | fan_trip;
  wire can_retry = restart_cnt < cfg.restart_attempt_count;
  wire diag_done = diag_sr[DIAG_CYC-1];
  wire clean_done = (clean_cnt >= 40'(CLEAN_RUN_CYCLES - 1));

  // Next-state choice for the run supervisor.
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (run_cmd_i && !any_hard && !any_elig) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (any_hard || (any_elig && !can_retry) || loss_stop || !run_cmd_i) begin
          next_state = (any_hard || any_elig) ? ST_TRIP : ST_IDLE;
        end else if (any_elig) begin
          next_state = ST_DIAG;
        end
      end
      ST_DIAG: begin
        if (diag_done) begin
          next_state = (diag_ok_i && !any_hard) ? ST_RUN : ST_TRIP;
        end
      end
      ST_TRIP: begin
        if (fault_reset_i && !any_hard && !any_elig) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Supervisor state, restart counter and clean-run timer.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      restart_cnt <= 4'h0;
      restarting <= 1'b0;
      clean_seen <= 1'b0;
      clean_cnt <= 40'h0;
      diag_sr <= '0;
    end else begin
      state <= next_state;
      diag_sr <= (state == ST_DIAG) ? {diag_sr[DIAG_CYC-2:0], 1'b1} : '0;
      if (state == ST_DIAG && next_state == ST_RUN) begin
        restart_cnt <= restart_cnt + 4'h1;
        restarting <= 1'b1;
        clean_cnt <= 40'h0;
      end else if (state == ST_TRIP && fault_reset_i) begin
        restart_cnt <= 4'h0;
        restarting <= 1'b0;
      end else if (state == ST_RUN && restarting) begin
        if (clean_done) begin
          restart_cnt <= 4'h0;
          restarting <= 1'b0;
          clean_cnt <= 40'h0;
        end else begin
          clean_cnt <= clean_cnt + 40'h1;
        end
      end
      clean_seen <= clean_done;
    end
  end

  // ---------------------------------------------------------------
  // Fan interval operation
  // ---------------------------------------------------------------
  // A millisecond tick builds seconds; the fan rests the first seconds of each minute.
  wire ms_tick = (tick_cnt >= 32'(TICK_CYCLES - 1));
  wire sec_tick = ms_tick & (sec_ms == 16'h03e7);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt <= 32'h0;
      sec_ms <= 16'h0;
      sec_in_min <= 6'h0;
    end else begin
      tick_cnt <= ms_tick ? 32'h0 : tick_cnt + 32'h1;
      if (ms_tick) begin
        sec_ms <= (sec_ms == 16'h03e7) ? 16'h0 : sec_ms + 16'h1;
      end
      if (!fan_fault_i) begin
        sec_in_min <= 6'h0;
      end else if (sec_tick) begin
        sec_in_min <= (32'(sec_in_min) == 32'(FAN_PERIOD_S - 1)) ? 6'h0 : sec_in_min + 6'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  wire fan_derate = fan_fault_i & ~cfg.fan_fault_response_sel & (state == ST_RUN);
  wire vt_duty = (cfg.duty_rating_sel != 2'h0);
  wire overload_s ol_norm = '{FULL_CURRENT_PCT, 10'h03c, CT_OL2_PCT, 10'h03c};
  wire overload_s ol_ct = '{CT_OL1_PCT, CT_OL1_S, CT_OL2_PCT, CT_OL2_S};
  wire overload_s ol_vt = '{VT_OL1_PCT, VT_OL1_S, VT_OL2_PCT, VT_OL2_S};
  wire alarm = fan_derate;
  wire tripped = (state == ST_TRIP);

  // Registered drive outputs.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_enable_o <= 1'b0;
      coast_stop_o <= 1'b0;
      freq_ref_o <= '0;
      current_limit_pct_o <= FULL_CURRENT_PCT;
      overload_o <= '0;
      fan_on_o <= 1'b0;
      fan_indication_o <= 1'b0;
    end else begin
      run_enable_o <= (state == ST_RUN) && !loss_stop;
      coast_stop_o <= tripped;
      freq_ref_o <= (ref_lost && cfg.loss_response_sel == LOSS_CONTINUE) ? post_ref
                                                                         : ref_value_i;
      current_limit_pct_o <= fan_derate ? FAN_CURRENT_PCT : FULL_CURRENT_PCT;
      overload_o <= !fan_derate ? ol_norm : (vt_duty ? ol_vt : ol_ct);
      fan_on_o <= !(fan_fault_i && 32'(sec_in_min) < 32'(FAN_OFF_S));
      fan_indication_o <= fan_derate & sec_ms[9];
    end
  end

  // Multi-function digital outputs, one selector each.
  generate
    for (genvar i = 0; i < DOUT_N; i++) begin : g_dout
      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          dout_o[i] <= 1'b0;
        end else begin
          dout_o[i] <= (dout_match(dout_sel[i], DOUT_REF_LOSS) & ref_lost)
                     | (dout_match(dout_sel[i], DOUT_RESTART) & restarting)
                     | (dout_match(dout_sel[i], DOUT_ALARM) & alarm)
                     | (dout_match(dout_sel[i], DOUT_FAN) & fan_fault_i)
                     | (dout_match(dout_sel[i], DOUT_FAULT) & tripped);
        end
      end
    end
  endgenerate

endmodule : drive_fault_ride_through

// [test/ride_through_properties.sv]
`timescale 1ns/100ps
module ride_through_properties
  import ride_through_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] readdata_o,
  input wire logic waitrequest_o,
  input wire logic [FAULT_W-1:0] fault_i,
  input wire logic fin_overheat_fault_i,
  input wire logic fan_fault_i,
  input wire logic fault_reset_i,
  input wire logic run_enable_o,
  input wire logic coast_stop_o,
  input wire logic [6:0] current_limit_pct_o,
  input wire overload_s overload_o
);
  // ---------------------------------------------------------------
  // Derated overload sets and named steps
  // ---------------------------------------------------------------
  localparam overload_s CT_SET = {CT_OL1_PCT, CT_OL1_S, CT_OL2_PCT, CT_OL2_S};
  localparam overload_s VT_SET = {VT_OL1_PCT, VT_OL1_S, VT_OL2_PCT, VT_OL2_S};
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence req_rise;
    (read_i || write_i) && !$past(read_i || write_i);
  endsequence
  sequence quiet_trip;
    !fault_reset_i ##1 (!fault_reset_i && coast_stop_o);
  endsequence
  sequence clean_reset;
    fault_reset_i && coast_stop_o && (fault_i == '0) && !fin_overheat_fault_i && !fan_fault_i;
  endsequence
  // A new request waits one cycle, then is answered.
  bus_answer_a: assert property (req_rise |-> waitrequest_o ##1 !waitrequest_o)
    else $error("Bus request not answered after one cycle.");
  read_hold_a: assert property (!read_i && !write_i |=> $stable(readdata_o))
    else $error("Read data changed without an access.");
  // Trip handling.
  trip_stops_a: assert property (coast_stop_o |-> !run_enable_o)
    else $error("Drive enabled while tripped.");
  fin_trip_a: assert property (run_enable_o && fin_overheat_fault_i |-> ##[1:4] coast_stop_o)
    else $error("Fin overheat did not trip.");
  other_trip_a: assert property (run_enable_o && fault_i[F_OTHER] |-> ##[1:4] coast_stop_o)
    else $error("Ineligible fault did not trip.");
  trip_latch_a: assert property (quiet_trip |=> coast_stop_o)
    else $error("Trip released without fault reset.");
  reset_clear_a: assert property (clean_reset |-> ##[1:4] !coast_stop_o)
    else $error("Fault reset did not clear trip.");
  // Current derating.
  limit_pair_a: assert property (current_limit_pct_o == FULL_CURRENT_PCT ||
                                 current_limit_pct_o == FAN_CURRENT_PCT)
    else $error("Current limit outside allowed values.");
  derate_ol_a: assert property (current_limit_pct_o == FAN_CURRENT_PCT |->
                                overload_o == CT_SET || overload_o == VT_SET)
    else $error("Derated overload set wrong.");
endmodule : ride_through_properties

// [test/plant_controller_model.sv]
`timescale 1ns/100ps
module plant_controller_model #(
  parameter int RESTART_BIT = 1
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic reset_en_i,
  input wire logic trip_i,
  input wire logic [2:0] dout_i,
  output logic fault_reset_o,
  output logic [7:0] restart_cnt_o
);
  logic [2:0] wait_cnt;
  logic restart_q;
  // Applies fault reset a few cycles after a trip and counts restart flags.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_cnt <= 3'h0;
      fault_reset_o <= 1'b0;
      restart_q <= 1'b0;
      restart_cnt_o <= 8'h00;
    end else begin
      wait_cnt <= (reset_en_i && trip_i) ? wait_cnt + 3'h1 : 3'h0;
      fault_reset_o <= reset_en_i && trip_i && (wait_cnt >= 3'h4);
      restart_q <= dout_i[RESTART_BIT];
      if (dout_i[RESTART_BIT] && !restart_q) begin
        restart_cnt_o <= restart_cnt_o + 8'h01;
      end
    end
  end
endmodule : plant_controller_model

// [test/tb_drive_fault_ride_through.sv]
`timescale 1ns/100ps
module tb_drive_fault_ride_through
  import ride_through_pkg::*;
;
  // ---------------------------------------------------------------
  // Stimulus, checks and helpers
  // ---------------------------------------------------------------
  localparam int ELIG[8] = '{F_OVERCURRENT, F_GROUND, F_BUS_FUSE, F_OVERVOLTAGE,
                             F_UNDERVOLTAGE, F_MOTOR_HEAT, F_OVERTORQUE, F_OUT_PHASE};
  localparam overload_s CT = {CT_OL1_PCT, CT_OL1_S, CT_OL2_PCT, CT_OL2_S};
  localparam overload_s VT = {VT_OL1_PCT, VT_OL1_S, VT_OL2_PCT, VT_OL2_S};
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] address_i = 4'h0;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0;
  logic run_cmd_i = 1'b0;
  logic analog_ref_sel_i = 1'b0;
  logic [11:0] ref_value_i = 12'h0;
  logic [FAULT_W-1:0] fault_i = '0;
  logic fin_overheat_fault_i = 1'b0;
  logic fan_fault_i = 1'b0;
  logic diag_ok_i = 1'b1;
  logic reset_en = 1'b0;
  logic fault_reset_i, waitrequest_o, run_enable_o, coast_stop_o, fan_indication_o, fan_on_o;
  logic [31:0] readdata_o;
  logic [11:0] freq_ref_o;
  logic [6:0] current_limit_pct_o;
  overload_s overload_o;
  logic [2:0] dout_o;
  logic [7:0] restart_cnt;
  logic [31:0] seed = 32'h22926695;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc_cnt = 0;

  drive_fault_ride_through #(.DOUT_N(3), .LOSS_WINDOW_CYCLES(100),
    .CLEAN_RUN_CYCLES(200), .TICK_CYCLES(2)) drive_fault_ride_through_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .run_cmd_i(run_cmd_i), .analog_ref_sel_i(analog_ref_sel_i),
    .ref_value_i(ref_value_i), .fault_i(fault_i), .fin_overheat_fault_i(fin_overheat_fault_i),
    .fan_fault_i(fan_fault_i), .diag_ok_i(diag_ok_i), .fault_reset_i(fault_reset_i),
    .run_enable_o(run_enable_o), .coast_stop_o(coast_stop_o), .freq_ref_o(freq_ref_o),
    .current_limit_pct_o(current_limit_pct_o), .overload_o(overload_o), .fan_on_o(fan_on_o),
    .fan_indication_o(fan_indication_o), .dout_o(dout_o));
  plant_controller_model #(.RESTART_BIT(1)) plant_controller_model_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reset_en_i(reset_en), .trip_i(coast_stop_o),
    .dout_i(dout_o), .fault_reset_o(fault_reset_i), .restart_cnt_o(restart_cnt));

  // Clock and a watchdog that cuts a hang short.
  always #2 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 30000) begin
      error_cnt = error_cnt + 1;
      end_sim();
    end
  end

  // Helpers for random values, settings words, bus cycles and comparisons.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] cfg(logic l, logic [3:0] n, logic [1:0] p, logic f,
                                      logic [1:0] d);
    return {7'h00, l, POST_LOSS_PCT_DEF, DETECT_WIDTH_DEF, n, p, f, 1'b0, d};
  endfunction : cfg
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : wait_cyc
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] d,
                     output logic [31:0] q);
    read_i <= !wr;
    write_i <= wr;
    address_i <= adr;
    writedata_i <= d;
    @(posedge ref_clk_i);
    while (waitrequest_o !== 1'b0) @(posedge ref_clk_i);
    q = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : bus
  task automatic stat_cnt(input logic [3:0] e);
    logic [31:0] q;
    bus(1'b0, 4'h2, 32'h0, q);
    check(q[3:0], e);
  endtask : stat_cnt
  task automatic pulse_fault(input int b);
    fault_i[b] <= 1'b1;
    wait_cyc(1 + rnd() % 4);
    fault_i <= '0;
    wait_cyc(40);
  endtask : pulse_fault
  task automatic trip_clear();
    check(coast_stop_o, 1'b1);
    fault_i <= '0;
    fin_overheat_fault_i <= 1'b0;
    fan_fault_i <= 1'b0;
    reset_en <= 1'b1;
    wait_cyc(20);
    check(coast_stop_o, 1'b0);
    reset_en <= 1'b0;
    wait_cyc(4);
  endtask : trip_clear
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  // Main sequence.
  initial begin
    logic [31:0] q;
    logic [11:0] r;
    logic hi;
    logic lo;
    wait_cyc(6);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    bus(1'b0, 4'h0, 32'h0, q);
    check(q, 32'h00a02808);
    stat_cnt(4'h0);
    bus(1'b1, 4'h9, 32'h12345678, q);
    bus(1'b0, 4'h9, 32'h0, q);
    check(q, 32'h0);
    bus(1'b1, 4'h1, 32'h0000e78c, q);
    $display("Test registers done");
    for (int l = 0; l < 2; l++) begin
      bus(1'b1, 4'h0, cfg(l[0], 4'h0, 2'h0, 1'b1, 2'h0), q);
      r = 12'(400 + rnd() % 3600);
      ref_value_i <= r;
      analog_ref_sel_i <= 1'b1;
      run_cmd_i <= 1'b1;
      wait_cyc(250);
      ref_value_i <= r / 12'd20;
      while (dout_o[0] !== 1'b1) @(posedge ref_clk_i);
      @(posedge ref_clk_i);
      check(run_enable_o, l[0]);
      if (l == 1) begin
        check(freq_ref_o, 12'(int'(r) * 80 / 100));
      end
      analog_ref_sel_i <= 1'b0;
      run_cmd_i <= 1'b0;
      wait_cyc(4);
      check(dout_o[0], 1'b0);
    end
    $display("Test reference loss done");
    bus(1'b1, 4'h0, cfg(1'b0, 4'h7, 2'h1, 1'b1, 2'h0), q);
    run_cmd_i <= 1'b1;
    wait_cyc(4);
    for (int k = 0; k < 8; k++) begin
      pulse_fault(ELIG[k]);
      if (k < 7) begin
        check(run_enable_o, 1'b1);
        stat_cnt(4'(k + 1));
      end
    end
    check(restart_cnt, 8'h01);
    trip_clear();
    stat_cnt(4'h0);
    bus(1'b1, 4'h0, cfg(1'b0, 4'h2, 2'h0, 1'b1, 2'h0), q);
    pulse_fault(F_UNDERVOLTAGE);
    trip_clear();
    pulse_fault(F_OTHER);
    trip_clear();
    diag_ok_i <= 1'b0;
    pulse_fault(F_OVERCURRENT);
    diag_ok_i <= 1'b1;
    trip_clear();
    pulse_fault(F_GROUND);
    stat_cnt(4'h1);
    wait_cyc(260);
    stat_cnt(4'h0);
    pulse_fault(F_GROUND);
    rst_n_i <= 1'b0;
    wait_cyc(6);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    stat_cnt(4'h0);
    pulse_fault(F_OVERCURRENT);
    trip_clear();
    $display("Test restart done");
    bus(1'b1, 4'h1, 32'h0003d78c, q);
    check(fan_on_o, 1'b1);
    for (int d = 0; d < 2; d++) begin
      bus(1'b1, 4'h0, cfg(1'b0, 4'h0, 2'h0, 1'b0, d[1:0]), q);
      fan_fault_i <= 1'b1;
      wait_cyc(10);
      check(run_enable_o, 1'b1);
      check(dout_o[2], 1'b1);
      check(current_limit_pct_o, FAN_CURRENT_PCT);
      check(fan_on_o, 1'b0);
      check(overload_o, d ? VT : CT);
    end
    hi = 1'b0;
    lo = 1'b0;
    repeat (1100) begin
      @(posedge ref_clk_i);
      hi = hi | (fan_indication_o === 1'b1);
      lo = lo | (fan_indication_o === 1'b0);
    end
    check(hi & lo, 1'b1);
    fin_overheat_fault_i <= 1'b1;
    wait_cyc(6);
    trip_clear();
    bus(1'b1, 4'h0, cfg(1'b0, 4'h0, 2'h0, 1'b1, 2'h0), q);
    fan_fault_i <= 1'b1;
    wait_cyc(6);
    trip_clear();
    $display("Test fan fault done");
    end_sim();
  end
endmodule : tb_drive_fault_ride_through

bind drive_fault_ride_through ride_through_properties ride_through_properties_i (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .read_i(read_i), .write_i(write_i),
  .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .fault_i(fault_i),
  .fin_overheat_fault_i(fin_overheat_fault_i), .fan_fault_i(fan_fault_i),
  .fault_reset_i(fault_reset_i), .run_enable_o(run_enable_o), .coast_stop_o(coast_stop_o),
  .current_limit_pct_o(current_limit_pct_o), .overload_o(overload_o));
